// [capsense_pkg.sv]
// constants and types shared by the capacitive sense scan/threshold block
package capsense_pkg;
  // ********************************************************
  // register map (special-function page and addresses)
  // ********************************************************
  localparam logic [7:0] CFG_PAGE = 8'h00;
  localparam logic [7:0] ADDR_SCAN_MASK_LOW = 8'hd2;
  localparam logic [7:0] ADDR_SCAN_MASK_HIGH = 8'hd3;
  localparam logic [7:0] ADDR_SCAN_START = 8'hdd;
  localparam logic [7:0] ADDR_SCAN_END = 8'hde;
  localparam logic [7:0] ADDR_THRESH_LOW = 8'hfd;
  localparam logic [7:0] ADDR_THRESH_HIGH = 8'hfe;
  localparam logic [7:0] RESET_VALUE = 8'h00;
  // ********************************************************
  // field layout
  // ********************************************************
  localparam int MASK_HIGH_WIDTH = 6;
  localparam int CH_WIDTH = 5;
  localparam int NUM_CH = 14;
  localparam logic [4:0] CH_RESET = 5'h00;
  // ********************************************************
  // start-of-conversion mode codes
  // ********************************************************
  localparam logic [2:0] MODE_SINGLE_SCAN = 3'h5;
  localparam logic [2:0] MODE_AUTO_SCAN = 3'h7;
  typedef enum logic {SEQ_IDLE, SEQ_RUN} seq_state_t;
endpackage

// [scan_sequencer.sv]
// channel sequencer stepping the mux through range or masked scans
`timescale 1ns/1ps
module scan_sequencer (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic start,
  input wire logic stop,
  input wire logic masked,
  input wire logic continuous,
  input wire logic [capsense_pkg::NUM_CH-1:0] mask,
  input wire logic [4:0] first_ch,
  input wire logic [4:0] last_ch,
  input wire logic conv_done,
  output logic load,
  output logic [4:0] load_ch,
  output logic running
);
  capsense_pkg::seq_state_t state, next_state;
  logic next_load;
  logic [4:0] next_ch;
  logic [4:0] lowest_ch;
  logic [4:0] above_ch;
  logic any_set;
  logic any_above;
  logic [capsense_pkg::NUM_CH-1:0] above;

  // ********************************************************
  // masked channel search
  // ********************************************************
  genvar g;
  generate
    for (g = 0; g < capsense_pkg::NUM_CH; g++) begin : g_above
      assign above[g] = mask[g] && (5'(g) > load_ch);
    end
  endgenerate

  always_comb begin
    lowest_ch = capsense_pkg::CH_RESET;
    above_ch = capsense_pkg::CH_RESET;
    any_set = 1'b0;
    any_above = 1'b0;
    for (int i = capsense_pkg::NUM_CH - 1; i >= 0; i--) begin
      if (mask[i]) begin
        lowest_ch = 5'(i);
        any_set = 1'b1;
      end
      if (above[i]) begin
        above_ch = 5'(i);
        any_above = 1'b1;
      end
    end
  end

  // ********************************************************
  // state machine
  // ********************************************************
  always_comb begin
    next_state = state;
    next_load = 1'b0;
    next_ch = load_ch;
    unique case (state)
      capsense_pkg::SEQ_IDLE: begin
        // an empty mask has nothing to scan, so the start is dropped
        if (start && (!masked || any_set)) begin
          next_state = capsense_pkg::SEQ_RUN;
          next_load = 1'b1;
          next_ch = masked ? lowest_ch : first_ch;
        end
      end
      capsense_pkg::SEQ_RUN: begin
        if (stop) begin
          next_state = capsense_pkg::SEQ_IDLE;
        end else if (conv_done && masked) begin
          if (any_above) begin
            next_load = 1'b1;
            next_ch = above_ch;
          end else if (continuous && any_set) begin
            next_load = 1'b1;
            next_ch = lowest_ch;
          end else begin
            next_state = capsense_pkg::SEQ_IDLE;
          end
        end else if (conv_done) begin
          next_load = 1'b1;
          // ascending, wrapping back to the start channel
          next_ch = (load_ch == last_ch) ? first_ch : load_ch + 5'h01;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= capsense_pkg::SEQ_IDLE;
      load <= 1'b0;
      load_ch <= capsense_pkg::CH_RESET;
    end else if (ce) begin
      state <= next_state;
      load <= next_load;
      load_ch <= next_ch;
    end
  end

  assign running = (state == capsense_pkg::SEQ_RUN);
endmodule

// [capsense_scan_threshold_regs.sv]
// scan masks, scan range and comparator threshold of the capacitive sensor
//
// Contract
// [RULE1] 8-bit low scan mask; set bits join the scan when masking is on.
// [RULE2] 6-bit high scan mask in bits 5:0; bits 7:6 read zero.
// [RULE3] 5-bit start channel: first channel of the range auto-scan.
// [RULE4] in auto-scan, writing start channel also loads the mux select.
// [RULE5] 5-bit end channel: last channel of the range auto-scan.
// [RULE6] start/end bits 7:5 read zero and ignore writes.
// [RULE7] high byte of the 16-bit comparator threshold.
// [RULE8] low byte of the 16-bit comparator threshold.
// [RULE9] registers live on page zero at d2, d3, dd, de, fd, fe.
// [RULE10] masked: code 101 scans mask once, 111 scans it continuously.
// [RULE11] unmasked code 111 loops start..end after a busy-bit write.
// [RULE12] comparator flag sets above threshold; software clears it.
// [RULE13] range scan ascends start to end, then returns to start.
`timescale 1ns/1ps
module capsense_scan_threshold_regs (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [7:0] sfr_page,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic scan_mask_enable,
  input wire logic [2:0] conversion_start_mode,
  input wire logic busy_write,
  input wire logic mux_wr,
  input wire logic [4:0] mux_wdata,
  input wire logic conv_done,
  input wire logic [15:0] conv_result,
  input wire logic flag_clear,
  output logic [4:0] input_mux_select,
  output logic comparator_flag,
  output logic scan_active
);
  logic [7:0] scan_mask_low, next_scan_mask_low;
  logic [5:0] scan_mask_high, next_scan_mask_high;
  logic [4:0] scan_start_channel, next_scan_start_channel;
  logic [4:0] scan_end_channel, next_scan_end_channel;
  logic [7:0] threshold_low_byte, next_threshold_low_byte;
  logic [7:0] threshold_high_byte, next_threshold_high_byte;
  logic [7:0] next_sfr_rdata;
  logic [4:0] next_input_mux_select;
  logic next_comparator_flag;
  logic page_ok;
  logic auto_scan;
  logic scan_start;
  logic scan_stop;
  logic seq_load;
  logic [4:0] seq_ch;
  logic [15:0] threshold;

  assign page_ok = (sfr_page == capsense_pkg::CFG_PAGE);
  assign auto_scan = (conversion_start_mode == capsense_pkg::MODE_AUTO_SCAN);
  assign threshold = {threshold_high_byte, threshold_low_byte};

  // ********************************************************
  // register writes
  // ********************************************************
  always_comb begin
    next_scan_mask_low = scan_mask_low;
    next_scan_mask_high = scan_mask_high;
    next_scan_start_channel = scan_start_channel;
    next_scan_end_channel = scan_end_channel;
    next_threshold_low_byte = threshold_low_byte;
    next_threshold_high_byte = threshold_high_byte;
    if (sfr_wr && page_ok) begin // [RULE9]
      unique case (sfr_addr)
        capsense_pkg::ADDR_SCAN_MASK_LOW:
          next_scan_mask_low = sfr_wdata; // [RULE1]
        capsense_pkg::ADDR_SCAN_MASK_HIGH:
          next_scan_mask_high = sfr_wdata[5:0]; // [RULE2]
        capsense_pkg::ADDR_SCAN_START:
          next_scan_start_channel = sfr_wdata[4:0]; // [RULE3] [RULE6]
        capsense_pkg::ADDR_SCAN_END:
          next_scan_end_channel = sfr_wdata[4:0]; // [RULE5] [RULE6]
        capsense_pkg::ADDR_THRESH_LOW:
          next_threshold_low_byte = sfr_wdata; // [RULE8]
        capsense_pkg::ADDR_THRESH_HIGH:
          next_threshold_high_byte = sfr_wdata; // [RULE7]
        default: begin
        end
      endcase
    end
  end

  // ********************************************************
  // register reads, answered one cycle after the strobe
  // ********************************************************
  always_comb begin
    next_sfr_rdata = sfr_rdata;
    if (sfr_rd) begin
      next_sfr_rdata = 8'h00;
      if (page_ok) begin
        unique case (sfr_addr)
          capsense_pkg::ADDR_SCAN_MASK_LOW: next_sfr_rdata = scan_mask_low;
          capsense_pkg::ADDR_SCAN_MASK_HIGH:
            next_sfr_rdata = {2'h0, scan_mask_high}; // [RULE2]
          capsense_pkg::ADDR_SCAN_START:
            next_sfr_rdata = {3'h0, scan_start_channel}; // [RULE6]
          capsense_pkg::ADDR_SCAN_END:
            next_sfr_rdata = {3'h0, scan_end_channel}; // [RULE6]
          capsense_pkg::ADDR_THRESH_LOW: next_sfr_rdata = threshold_low_byte;
          capsense_pkg::ADDR_THRESH_HIGH:
            next_sfr_rdata = threshold_high_byte;
          default: next_sfr_rdata = 8'h00;
        endcase
      end
    end
  end

  // ********************************************************
  // scan control and mux select
  // ********************************************************
  assign scan_start = busy_write && (auto_scan ||
    (scan_mask_enable &&
     conversion_start_mode == capsense_pkg::MODE_SINGLE_SCAN)); // [RULE10]
  // any other mode code ends a running scan
  assign scan_stop = !auto_scan &&
    conversion_start_mode != capsense_pkg::MODE_SINGLE_SCAN;

  scan_sequencer u_seq (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .start(scan_start),
    .stop(scan_stop),
    .masked(scan_mask_enable),
    .continuous(auto_scan),
    .mask({scan_mask_high, scan_mask_low}),
    .first_ch(scan_start_channel),
    .last_ch(scan_end_channel),
    .conv_done(conv_done),
    .load(seq_load),
    .load_ch(seq_ch),
    .running(scan_active)
  );

  always_comb begin
    next_input_mux_select = input_mux_select;
    // a sequencer load beats software writes in the same cycle; between loads the writes still land
    if (seq_load) begin
      next_input_mux_select = seq_ch; // [RULE11] [RULE13]
    end else if (sfr_wr && page_ok && auto_scan &&
                 sfr_addr == capsense_pkg::ADDR_SCAN_START) begin
      next_input_mux_select = sfr_wdata[4:0]; // [RULE4]
    end else if (mux_wr) begin
      next_input_mux_select = mux_wdata;
    end
  end

  // ********************************************************
  // comparator flag
  // ********************************************************
  always_comb begin
    next_comparator_flag = comparator_flag;
    if (flag_clear) begin
      next_comparator_flag = 1'b0;
    end
    // set beats a clear in the same cycle so no event is lost
    if (conv_done && conv_result > threshold) begin
      next_comparator_flag = 1'b1; // [RULE12]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scan_mask_low <= capsense_pkg::RESET_VALUE;
      scan_mask_high <= 6'h00;
      scan_start_channel <= capsense_pkg::CH_RESET;
      scan_end_channel <= capsense_pkg::CH_RESET;
      threshold_low_byte <= capsense_pkg::RESET_VALUE;
      threshold_high_byte <= capsense_pkg::RESET_VALUE;
      sfr_rdata <= capsense_pkg::RESET_VALUE;
      input_mux_select <= capsense_pkg::CH_RESET;
      comparator_flag <= 1'b0;
    end else if (ce) begin
      scan_mask_low <= next_scan_mask_low;
      scan_mask_high <= next_scan_mask_high;
      scan_start_channel <= next_scan_start_channel;
      scan_end_channel <= next_scan_end_channel;
      threshold_low_byte <= next_threshold_low_byte;
      threshold_high_byte <= next_threshold_high_byte;
      sfr_rdata <= next_sfr_rdata;
      input_mux_select <= next_input_mux_select;
      comparator_flag <= next_comparator_flag;
    end
  end

  // ********************************************************
  // assertions
  // ********************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_wr(logic [7:0] a);
    ce && sfr_wr && page_ok && sfr_addr == a;
  endsequence

  sequence s_rd(logic [7:0] a);
    ce && sfr_rd && page_ok && sfr_addr == a;
  endsequence

  a_mask_low_write: assert property ( // [RULE1]
    s_wr(capsense_pkg::ADDR_SCAN_MASK_LOW) |=>
      scan_mask_low == $past(sfr_wdata))
    else $error("low scan mask not written");

  a_mask_high_read: assert property ( // [RULE2]
    s_rd(capsense_pkg::ADDR_SCAN_MASK_HIGH) |=>
      sfr_rdata == {2'h0, $past(scan_mask_high)})
    else $error("high scan mask read wrong");

  a_start_write: assert property ( // [RULE3]
    s_wr(capsense_pkg::ADDR_SCAN_START) |=>
      scan_start_channel == $past(sfr_wdata[4:0]))
    else $error("start channel not written");

  a_start_loads_mux: assert property ( // [RULE4]
    s_wr(capsense_pkg::ADDR_SCAN_START) and auto_scan && !seq_load |=>
      input_mux_select == $past(sfr_wdata[4:0]))
    else $error("start write did not load mux");

  a_end_write: assert property ( // [RULE5]
    s_wr(capsense_pkg::ADDR_SCAN_END) |=>
      scan_end_channel == $past(sfr_wdata[4:0]))
    else $error("end channel not written");

  a_range_upper_zero: assert property ( // [RULE6]
    s_rd(capsense_pkg::ADDR_SCAN_START) or s_rd(capsense_pkg::ADDR_SCAN_END)
      |=> sfr_rdata[7:5] == 3'h0)
    else $error("unused channel bits not zero");

  a_thresh_high_write: assert property ( // [RULE7]
    s_wr(capsense_pkg::ADDR_THRESH_HIGH) |=>
      threshold_high_byte == $past(sfr_wdata))
    else $error("threshold high byte not written");

  a_thresh_low_write: assert property ( // [RULE8]
    s_wr(capsense_pkg::ADDR_THRESH_LOW) |=>
      threshold_low_byte == $past(sfr_wdata))
    else $error("threshold low byte not written");

  a_other_page_ignored: assert property ( // [RULE9]
    ce && sfr_wr && !page_ok |=> $stable(threshold) &&
      $stable(scan_mask_low) && $stable(scan_start_channel))
    else $error("write on other page took effect");

  sequence s_masked_start;
    ce && scan_start && scan_mask_enable && !scan_active &&
      scan_mask_low[0] ##1 ce ##1 ce;
  endsequence

  a_masked_first: assert property ( // [RULE10]
    s_masked_start |-> input_mux_select == 5'h00 && scan_active)
    else $error("masked scan did not start at lowest channel");

  sequence s_range_wrap;
    ce && scan_active && !scan_mask_enable && auto_scan && conv_done &&
      input_mux_select == scan_end_channel && !seq_load && !mux_wr
      ##1 ce ##1 ce;
  endsequence

  // the wrap target is the start channel as it stood at the last conversion
  a_range_wrap: assert property ( // [RULE11] [RULE13]
    s_range_wrap |-> input_mux_select == $past(scan_start_channel, 2))
    else $error("range scan did not return to start");

  a_flag_sets: assert property ( // [RULE12]
    ce && conv_done && conv_result > threshold |=> comparator_flag)
    else $error("comparator flag not set");

  a_flag_holds: assert property ( // [RULE12]
    comparator_flag && !(ce && flag_clear) |=> comparator_flag[*2]
      or ##1 $fell(comparator_flag) ##0 $past(ce && flag_clear))
    else $error("comparator flag dropped without clear");
endmodule

// [capsense_electrode_model.sv]
// behavioural sense converter standing in for the touch electrodes
`timescale 1ns/1ps
module capsense_electrode_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic go,
  input wire logic [3:0] gap,
  input wire logic [4:0] channel,
  output logic done,
  output logic [15:0] result
);
  logic [3:0] cnt;
  logic [15:0] last;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 4'h0;
      done <= 1'b0;
      last <= 16'h0000;
    end else begin
      done <= go && cnt == gap;
      cnt <= (!go || cnt == gap) ? 4'h0 : cnt + 4'h1;
      if (go && cnt == gap)
        last <= 16'h0100 + {11'h000, channel};
    end
  end
  // result is only valid with done; otherwise it changes each cycle while go counts and holds ~last while idle
  assign result = done ? last : ~last ^ {12'h000, cnt};
endmodule

// [capsense_scan_threshold_regs_tb_top.sv]
// self-checking bench for the scan mask, range and threshold registers
`timescale 1ns/1ps
module capsense_scan_threshold_regs_tb_top;
  logic clk, rst_n, ce, sfr_wr, sfr_rd, mask_en, busy_write, mux_wr;
  logic [7:0] sfr_page, sfr_addr, sfr_wdata, sfr_rdata;
  logic [2:0] mode;
  logic [4:0] mux_wdata, mux;
  logic [15:0] t_res, m_res, conv_result;
  logic t_done, m_done, conv_done, flag_clear, flag, active;
  logic [3:0] gap;
  int miscompares;
  int n_tests;
  assign conv_done = t_done | m_done;
  assign conv_result = t_done ? t_res : m_res;
  capsense_scan_threshold_regs u_capsense_scan_threshold_regs (
    .clk(clk), .rst_n(rst_n), .ce(ce), .sfr_page(sfr_page),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .scan_mask_enable(mask_en), .conversion_start_mode(mode),
    .busy_write(busy_write), .mux_wr(mux_wr), .mux_wdata(mux_wdata),
    .conv_done(conv_done), .conv_result(conv_result),
    .flag_clear(flag_clear), .input_mux_select(mux),
    .comparator_flag(flag), .scan_active(active));
  capsense_electrode_model u_capsense_electrode_model (
    .clk(clk), .rst_n(rst_n), .go(active), .gap(gap), .channel(mux),
    .done(m_done), .result(m_res));
  // ********************************************************
  // shared tasks
  // ********************************************************
  task automatic chk(input string name, input logic [15:0] exp, got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // strobes drop with an idle cycle after, so calls may follow back to back
  task automatic wr(input logic [7:0] a, d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    cyc(1);
    sfr_wr = 1'b0;
    cyc(1);
  endtask
  task automatic rd(input logic [7:0] a, exp);
    sfr_addr = a;
    sfr_rd = 1'b1;
    cyc(1);
    sfr_rd = 1'b0;
    chk("read data", {8'h00, exp}, {8'h00, sfr_rdata});
    cyc(1);
  endtask
  task automatic conv(input logic [15:0] r, input logic e);
    t_res = r;
    t_done = 1'b1;
    cyc(1);
    t_done = 1'b0;
    chk("comparator flag", {15'h0000, e}, {15'h0000, flag});
    cyc(1);
  endtask
  task automatic busy();
    busy_write = 1'b1;
    cyc(1);
    busy_write = 1'b0;
    cyc(2);
  endtask
  task automatic next_mux(input logic [4:0] exp);
    logic [4:0] old;
    int i;
    old = mux;
    i = 0;
    while (mux === old && i < 40) begin
      cyc(1);
      i++;
    end
    chk("mux step", {11'h000, exp}, {11'h000, mux});
  endtask
  // ********************************************************
  // scenarios
  // ********************************************************
  task automatic test_regs();
    logic [7:0] addr [6];
    logic [7:0] keep [6];
    addr = '{capsense_pkg::ADDR_SCAN_MASK_LOW,
      capsense_pkg::ADDR_SCAN_MASK_HIGH, capsense_pkg::ADDR_SCAN_START,
      capsense_pkg::ADDR_SCAN_END, capsense_pkg::ADDR_THRESH_LOW,
      capsense_pkg::ADDR_THRESH_HIGH};
    keep = '{8'hff, 8'h3f, 8'h1f, 8'h1f, 8'hff, 8'hff};
    chk("mux at reset", 16'h0000, {11'h000, mux});
    chk("outputs at reset", 16'h0000, {14'h0000, flag, active});
    for (int i = 0; i < 6; i++)
      rd(addr[i], 8'h00);
    for (int i = 0; i < 6; i++)
      wr(addr[i], 8'hff);
    for (int i = 0; i < 6; i++)
      rd(addr[i], keep[i]);
    sfr_page = 8'h01;
    wr(capsense_pkg::ADDR_SCAN_MASK_LOW, 8'h00);
    sfr_page = 8'h00;
    rd(capsense_pkg::ADDR_SCAN_MASK_LOW, 8'hff);
    wr(8'hd4, 8'h55);
    rd(8'hd4, 8'h00);
    // a frozen clock enable must swallow the write
    ce = 1'b0;
    wr(capsense_pkg::ADDR_SCAN_MASK_LOW, 8'h00);
    ce = 1'b1;
    rd(capsense_pkg::ADDR_SCAN_MASK_LOW, 8'hff);
    $display("register map test done");
  endtask
  task automatic test_thresh();
    wr(capsense_pkg::ADDR_THRESH_HIGH, 8'h12);
    wr(capsense_pkg::ADDR_THRESH_LOW, 8'h34);
    conv(16'h1234, 1'b0);
    conv(16'h0fff, 1'b0);
    conv(16'h1235, 1'b1);
    conv(16'h0001, 1'b1);
    flag_clear = 1'b1;
    cyc(1);
    flag_clear = 1'b0;
    chk("flag cleared", 16'h0000, {15'h0000, flag});
    cyc(1);
    // a clear landing with a new event must not lose the event
    t_res = 16'h2000;
    {t_done, flag_clear} = 2'b11;
    cyc(1);
    {t_done, flag_clear} = 2'b00;
    chk("set beats clear", 16'h0001, {15'h0000, flag});
    flag_clear = 1'b1;
    cyc(1);
    flag_clear = 1'b0;
    chk("flag cleared again", 16'h0000, {15'h0000, flag});
    cyc(1);
    $display("threshold test done");
  endtask
  task automatic test_range();
    gap = 4'h3;
    mux_wdata = 5'h07;
    mux_wr = 1'b1;
    cyc(1);
    mux_wr = 1'b0;
    chk("direct mux write", 16'h0007, {11'h000, mux});
    mode = capsense_pkg::MODE_AUTO_SCAN;
    wr(capsense_pkg::ADDR_SCAN_END, 8'he5);
    wr(capsense_pkg::ADDR_SCAN_START, 8'he3);
    chk("start write loads mux", 16'h0003, {11'h000, mux});
    busy();
    chk("range scan running", 16'h0001, {15'h0000, active});
    chk("first channel", 16'h0003, {11'h000, mux});
    next_mux(5'h04);
    next_mux(5'h05);
    next_mux(5'h03);
    mode = 3'h0;
    cyc(4);
    chk("range scan stopped", 16'h0000, {15'h0000, active});
    // single-scan code means nothing with masking off
    mode = capsense_pkg::MODE_SINGLE_SCAN;
    busy();
    chk("unmasked single refused", 16'h0000, {15'h0000, active});
    $display("range scan test done");
  endtask
  task automatic test_masked(input logic [2:0] m, input logic [3:0] g);
    gap = g;
    mask_en = 1'b1;
    wr(capsense_pkg::ADDR_SCAN_MASK_LOW, 8'h12);
    wr(capsense_pkg::ADDR_SCAN_MASK_HIGH, 8'hc1);
    mode = m;
    busy();
    chk("masked first", 16'h0001, {11'h000, mux});
    chk("masked running", 16'h0001, {15'h0000, active});
    next_mux(5'h04);
    next_mux(5'h08);
    if (m == capsense_pkg::MODE_SINGLE_SCAN) begin
      cyc(3 * g + 8);
      chk("single scan ended", 16'h0000, {15'h0000, active});
      // channel 0 in the mask: the scan must open on it
      wr(capsense_pkg::ADDR_SCAN_MASK_LOW, 8'h01);
      busy();
      chk("masked lowest", 16'h0000, {11'h000, mux});
      cyc(3 * g + 8);
      chk("rescan ended", 16'h0000, {15'h0000, active});
    end else begin
      next_mux(5'h01);
      mode = 3'h0;
      cyc(4);
    end
    mask_en = 1'b0;
    $display("masked scan test done");
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #100000;
    miscompares++;
    end_sim();
  end
  initial begin
    {rst_n, sfr_wr, sfr_rd, mask_en, busy_write, mux_wr} = 6'h00;
    {t_done, flag_clear, mode, mux_wdata} = 10'h000;
    {sfr_page, sfr_addr, sfr_wdata, t_res} = 40'h0;
    ce = 1'b1;
    gap = 4'h3;
    miscompares = 0;
    n_tests = 0;
    repeat (12) @(posedge clk);
    #1;
    rst_n = 1'b1;
    test_regs();
    test_thresh();
    test_range();
    test_masked(capsense_pkg::MODE_SINGLE_SCAN, 4'h3);
    test_masked(capsense_pkg::MODE_AUTO_SCAN, 4'h9);
    end_sim();
  end
endmodule
